// ---- core/dprc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Number-format bit 7 set means incoming samples are offset binary.
// - Number-format bit clear means incoming samples are two's complement.
// - Single-port bit 6 clear takes I from port 1 and Q from port 2.
// - Single-port bit set takes I and Q interleaved on port 1 and splits them.
// - Bit 4 turns the clock-pin loop on only with pin as input and not both lock pin option and PLL on.
// - Bit 3 clear makes the rate clock pin an input unless lock pin option and PLL are on, set makes the device drive it.
// - Status bit 2 reads 1 once the loop has locked at any time while enabled.
// - Status bit 1 reads 1 if the loop moved phase to relock after first lock.
// - Status bit 0 reads 1 while the loop shows cycle jitter, else 0.
// - Without sideband mode, bit 7 of the filter register picks I or Q for the converter.
// - With sideband mode, bit 6 of the filter register picks real or imaginary output.
// - Lock pin option with PLL on drives the PLL lock level onto the shared pin.
// - Sideband mode makes the modulator use both paths and selects which pick bit rules.
module dprc_top
(
	input  wire logic                           I_CLK,
	input  wire logic                           I_NRST,
	input  wire logic                           I_LCLK,
	input  wire logic [7:0]                     I_AWADDR,
	input  wire logic                           I_AWVALID,
	output logic                                O_AWREADY,
	input  wire logic [31:0]                    I_WDATA,
	input  wire logic [3:0]                     I_WSTRB,
	input  wire logic                           I_WVALID,
	output logic                                O_WREADY,
	output logic [1:0]                          O_BRESP,
	output logic                                O_BVALID,
	input  wire logic                           I_BREADY,
	input  wire logic [7:0]                     I_ARADDR,
	input  wire logic                           I_ARVALID,
	output logic                                O_ARREADY,
	output logic [31:0]                         O_RDATA,
	output logic [1:0]                          O_RRESP,
	output logic                                O_RVALID,
	input  wire logic                           I_RREADY,
	input  wire logic                           I_LOOP_LOCK,
	input  wire logic                           I_LOOP_SLIP,
	input  wire logic                           I_LOOP_JITTER,
	input  wire logic                           I_PLL_LOCK,
	output logic                                O_LOOP_EN,
	output logic                                O_DUAL_PATH,
	output logic                                O_RCLK_PIN_OUT,
	output logic                                O_RCLK_PIN_OE_N,
	input  wire logic [dprc_pkg::SAMPLE_W-1:0]  I_PORT1,
	input  wire logic [dprc_pkg::SAMPLE_W-1:0]  I_PORT2,
	input  wire logic                           I_IQ_SEL,
	output logic      [dprc_pkg::SAMPLE_W-1:0]  O_DAC_DATA,
	output logic                                O_DAC_VALID
);
	typedef struct packed {
		logic                 awready;
		logic                 wready;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 arready;
		logic                 rvalid;
		logic [1:0]           rresp;
		logic [31:0]          rdata;
		logic                 aw_full;
		logic                 w_full;
		logic [7:0]           awaddr;
		logic [7:0]           wdata;
		logic                 wlane0;
		logic [7:0]           data_ctrl;
		logic [7:0]           filt2;
		logic [7:0]           aux;
		logic [3:0]           sy1;
		logic [3:0]           sy2;
		logic                 ever;
		logic                 slip;
		logic                 jit;
		logic                 loop_en;
		logic                 dual;
		logic [2:0]           div_cnt;
		logic                 div_clk;
		logic                 pin_out;
		logic                 pin_oe_n;
		dprc_pkg::dprc_cfg_t  cfg;
	} dprc_top_st_t;

	dprc_top_st_t r;
	dprc_top_st_t n;

	logic lock_opt;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;

	assign lock_opt = r.aux[dprc_pkg::BIT_LOCK_ON_PIN] & r.aux[dprc_pkg::BIT_PLL_ON];
	assign aw_take  = I_AWVALID & r.awready;
	assign w_take   = I_WVALID & r.wready;
	assign ar_take  = I_ARVALID & r.arready;
	assign do_write = r.aw_full & r.w_full & ~r.bvalid;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		n = r;

		// Write channel: address and data taken in either order
		if (aw_take)
		begin
			n.aw_full = 1'b1;
			n.awaddr = I_AWADDR;
		end
		if (w_take)
		begin
			n.w_full = 1'b1;
			n.wdata = I_WDATA[7:0];
			n.wlane0 = I_WSTRB[0];
		end
		if (r.bvalid && I_BREADY)
			n.bvalid = 1'b0;
		if (do_write)
		begin
			n.aw_full = 1'b0;
			n.w_full = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = dprc_pkg::RESP_OKAY;
			// Status bits are masked out of the write
			if (r.awaddr == dprc_pkg::ADDR_DATA_CTRL)
			begin
				if (r.wlane0)
					n.data_ctrl = dprc_pkg::merge_bits(r.data_ctrl, r.wdata,
						dprc_pkg::WMASK_DATA_CTRL);
			end
			else if (r.awaddr == dprc_pkg::ADDR_FILT_MODE2)
			begin
				if (r.wlane0)
					n.filt2 = dprc_pkg::merge_bits(r.filt2, r.wdata,
						dprc_pkg::WMASK_FILT_MOD2);
			end
			else if (r.awaddr == dprc_pkg::ADDR_ROUTE_AUX)
			begin
				if (r.wlane0)
					n.aux = dprc_pkg::merge_bits(r.aux, r.wdata,
						dprc_pkg::WMASK_ROUTE_AUX);
			end
			else
				n.bresp = dprc_pkg::RESP_SLVERR;
		end
		n.awready = ~n.aw_full & ~n.bvalid;
		n.wready = ~n.w_full & ~n.bvalid;

		// Read channel: one word, answered the cycle after the address
		if (r.rvalid && I_RREADY)
			n.rvalid = 1'b0;
		if (ar_take)
		begin
			n.rvalid = 1'b1;
			n.rresp = dprc_pkg::RESP_OKAY;
			n.rdata = 32'h0000_0000;
			if (I_ARADDR == dprc_pkg::ADDR_DATA_CTRL)
				n.rdata[7:0] = {r.data_ctrl[7:3], r.ever, r.slip, r.jit};
			else if (I_ARADDR == dprc_pkg::ADDR_FILT_MODE2)
				n.rdata[7:0] = r.filt2;
			else if (I_ARADDR == dprc_pkg::ADDR_ROUTE_AUX)
				n.rdata[7:0] = r.aux;
			else
				n.rresp = dprc_pkg::RESP_SLVERR;
		end
		n.arready = ~n.rvalid;

		// Loop and PLL status pins, two flops each
		n.sy1 = {I_PLL_LOCK, I_LOOP_JITTER, I_LOOP_SLIP, I_LOOP_LOCK};
		n.sy2 = r.sy1;

		// Loop runs only when the pin is an input and not a lock indicator
		n.loop_en = r.data_ctrl[dprc_pkg::BIT_LOOP_ENABLE]
			& ~r.data_ctrl[dprc_pkg::BIT_PIN_DIR] & ~lock_opt;

		// Status means nothing with the loop off, so it is held clear then
		if (!r.loop_en)
		begin
			n.ever = 1'b0;
			n.slip = 1'b0;
			n.jit = 1'b0;
		end
		else
		begin
			if (r.sy2[0])
				n.ever = 1'b1;
			if (r.ever && r.sy2[1])
				n.slip = 1'b1;
			n.jit = r.sy2[2];
		end

		// Rate clock made from the system clock when the device drives it
		if (r.div_cnt == dprc_pkg::RATE_DIV_HALF)
		begin
			n.div_cnt = 3'h0;
			n.div_clk = ~r.div_clk;
		end
		else
			n.div_cnt = r.div_cnt + 3'h1;

		if (lock_opt)
		begin
			n.pin_out = r.sy2[3];
			n.pin_oe_n = 1'b0;
		end
		else
		begin
			n.pin_out = r.div_clk;
			n.pin_oe_n = ~r.data_ctrl[dprc_pkg::BIT_PIN_DIR];
		end

		// Registered ahead of the crossing so the link sees clean levels
		n.dual = r.aux[dprc_pkg::BIT_SSB_ENABLE];
		n.cfg.fmt_unsigned = r.data_ctrl[dprc_pkg::BIT_NUM_FORMAT];
		n.cfg.single_port = r.data_ctrl[dprc_pkg::BIT_SINGLE_PORT];
		n.cfg.pick_q = r.aux[dprc_pkg::BIT_SSB_ENABLE]
			? r.filt2[dprc_pkg::BIT_REAL_IMAG]
			: r.filt2[dprc_pkg::BIT_CHAN_PICK];
	end

	always_ff @(posedge I_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			r <= '0;
			r.data_ctrl <= dprc_pkg::RST_DATA_CTRL;
			r.filt2 <= dprc_pkg::RST_FILT_MODE2;
			r.aux <= dprc_pkg::RST_ROUTE_AUX;
			r.pin_oe_n <= 1'b1;
		end
		else
			r <= n;
	end

	// ----------------------------------------------------------------
	// Link side
	// ----------------------------------------------------------------
	dprc_link u_dprc_link
	(
		.i_lclk      (I_LCLK),
		.i_nrst      (I_NRST),
		.i_cfg       (r.cfg),
		.i_port1     (I_PORT1),
		.i_port2     (I_PORT2),
		.i_iq_sel    (I_IQ_SEL),
		.o_dac_data  (O_DAC_DATA),
		.o_dac_valid (O_DAC_VALID)
	);

	assign O_AWREADY       = r.awready;
	assign O_WREADY        = r.wready;
	assign O_BVALID        = r.bvalid;
	assign O_BRESP         = r.bresp;
	assign O_ARREADY       = r.arready;
	assign O_RVALID        = r.rvalid;
	assign O_RRESP         = r.rresp;
	assign O_RDATA         = r.rdata;
	assign O_LOOP_EN       = r.loop_en;
	assign O_DUAL_PATH     = r.dual;
	assign O_RCLK_PIN_OUT  = r.pin_out;
	assign O_RCLK_PIN_OE_N = r.pin_oe_n;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_loop_enable: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		##1 O_LOOP_EN == ($past(r.data_ctrl[dprc_pkg::BIT_LOOP_ENABLE])
		&& !$past(r.data_ctrl[dprc_pkg::BIT_PIN_DIR]) && !$past(lock_opt)))
		else $error("loop enable does not follow its gating");

	a_ever_held: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		r.ever && r.loop_en |=> r.ever)
		else $error("ever-locked bit dropped while loop enabled");

	a_ever_cause: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		$rose(r.ever) |-> $past(r.sy2[0]) && $past(r.loop_en))
		else $error("ever-locked set without lock");

	a_slip_after_lock: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		$rose(r.slip) |-> $past(r.ever) && $past(r.sy2[1]))
		else $error("slip flagged before first lock");

	a_jitter_follows: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		r.loop_en && r.sy2[2] |=> r.jit)
		else $error("jitter not reported");

	a_pin_lock_out: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		lock_opt |=> !O_RCLK_PIN_OE_N && O_RCLK_PIN_OUT == $past(r.sy2[3]))
		else $error("lock level not on shared pin");

	a_pin_input: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		!lock_opt && !r.data_ctrl[dprc_pkg::BIT_PIN_DIR] |=> O_RCLK_PIN_OE_N)
		else $error("pin driven while configured as input");

	a_pick_source: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		##1 r.cfg.pick_q == ($past(r.aux[dprc_pkg::BIT_SSB_ENABLE])
		? $past(r.filt2[dprc_pkg::BIT_REAL_IMAG])
		: $past(r.filt2[dprc_pkg::BIT_CHAN_PICK])))
		else $error("wrong pick bit for sideband mode");

	a_status_ro: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		do_write && r.awaddr == dprc_pkg::ADDR_DATA_CTRL && r.loop_en
		|=> r.ever == ($past(r.ever) || $past(r.sy2[0])) && r.jit == $past(r.sy2[2]))
		else $error("status bits took a write");

	a_status_off: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		!r.loop_en |=> !r.ever && !r.slip && !r.jit)
		else $error("loop status kept while loop off");

	a_write_resp: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		aw_take && w_take && !r.bvalid |=> ##1 O_BVALID)
		else $error("write response missing");

	a_slip_held: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		r.slip && r.loop_en |=> r.slip)
		else $error("slip bit dropped while loop enabled");

	a_pin_output: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		!lock_opt && r.data_ctrl[dprc_pkg::BIT_PIN_DIR]
		|=> !O_RCLK_PIN_OE_N && O_RCLK_PIN_OUT == $past(r.div_clk))
		else $error("rate clock not driven out");

	a_read_answer: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		ar_take |=> O_RVALID && !O_ARREADY)
		else $error("read not answered next cycle");

	a_write_stall: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		O_BVALID |-> !O_AWREADY && !O_WREADY)
		else $error("write taken while response pending");

	a_dual_follows: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		##1 O_DUAL_PATH == $past(r.aux[dprc_pkg::BIT_SSB_ENABLE]))
		else $error("dual path flag not tracking sideband mode");

	c_locked: cover property (@(posedge I_CLK) disable iff (!I_NRST)
		r.loop_en ##1 $rose(r.ever));
	c_slipped: cover property (@(posedge I_CLK) disable iff (!I_NRST)
		$rose(r.slip));
	c_pin_driven: cover property (@(posedge I_CLK) disable iff (!I_NRST)
		$fell(O_RCLK_PIN_OE_N));
	c_lock_pin: cover property (@(posedge I_CLK) disable iff (!I_NRST)
		lock_opt ##1 !O_RCLK_PIN_OE_N);
endmodule
`default_nettype wire

// ---- include/dprc_pkg.sv ----
`default_nettype none
package dprc_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_DATA_CTRL  = 8'h02;
	localparam logic [7:0] IDX_FILT_MODE2 = 8'h03;
	localparam logic [7:0] IDX_ROUTE_AUX  = 8'h04;
	localparam logic [7:0] ADDR_DATA_CTRL  = 8'(IDX_DATA_CTRL * 4);
	localparam logic [7:0] ADDR_FILT_MODE2 = 8'(IDX_FILT_MODE2 * 4);
	localparam logic [7:0] ADDR_ROUTE_AUX  = 8'(IDX_ROUTE_AUX * 4);

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_NUM_FORMAT  = 7;
	localparam int BIT_SINGLE_PORT = 6;
	localparam int BIT_LOOP_ENABLE = 4;
	localparam int BIT_PIN_DIR     = 3;
	localparam int BIT_EVER_LOCKED = 2;
	localparam int BIT_PHASE_SLIP  = 1;
	localparam int BIT_JITTER_SEEN = 0;
	localparam int BIT_CHAN_PICK   = 7;
	localparam int BIT_REAL_IMAG   = 6;
	localparam int BIT_LOCK_ON_PIN = 0;
	localparam int BIT_SSB_ENABLE  = 1;
	localparam int BIT_PLL_ON      = 2;

	// ----------------------------------------------------------------
	// Reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_DATA_CTRL   = 8'h00;
	localparam logic [7:0] RST_FILT_MODE2  = 8'h00;
	localparam logic [7:0] RST_ROUTE_AUX   = 8'h00;
	localparam logic [7:0] WMASK_DATA_CTRL = 8'hF8;
	localparam logic [7:0] WMASK_FILT_MOD2 = 8'hFF;
	localparam logic [7:0] WMASK_ROUTE_AUX = 8'h07;

	// ----------------------------------------------------------------
	// Bus answers, timing, sample width
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] RATE_DIV_HALF = 3'h3;
	localparam int SAMPLE_W = 12;

	typedef struct packed {
		logic fmt_unsigned;
		logic single_port;
		logic pick_q;
	} dprc_cfg_t;

	function automatic logic [7:0] merge_bits(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] mask);
		merge_bits = (old_v & ~mask) | (new_v & mask);
	endfunction

	function automatic logic [SAMPLE_W-1:0] to_twos(input logic [SAMPLE_W-1:0] s,
		input logic is_unsigned);
		to_twos = is_unsigned ? {~s[SAMPLE_W-1], s[SAMPLE_W-2:0]} : s;
	endfunction

endpackage
`default_nettype wire

// ---- core/dprc_link.sv ----
`timescale 1ns/1ps
`default_nettype none
module dprc_link
(
	input  wire logic                           i_lclk,
	input  wire logic                           i_nrst,
	input  wire dprc_pkg::dprc_cfg_t            i_cfg,
	input  wire logic [dprc_pkg::SAMPLE_W-1:0]  i_port1,
	input  wire logic [dprc_pkg::SAMPLE_W-1:0]  i_port2,
	input  wire logic                           i_iq_sel,
	output logic      [dprc_pkg::SAMPLE_W-1:0]  o_dac_data,
	output logic                                o_dac_valid
);
	typedef struct packed {
		dprc_pkg::dprc_cfg_t            cfg_s1;
		dprc_pkg::dprc_cfg_t            cfg_s2;
		dprc_pkg::dprc_cfg_t            cfg_s3;
		dprc_pkg::dprc_cfg_t            cfg_use;
		logic [dprc_pkg::SAMPLE_W-1:0]  i_hold;
		logic [dprc_pkg::SAMPLE_W-1:0]  dac;
		logic                           valid;
	} dprc_link_st_t;

	dprc_link_st_t r;
	dprc_link_st_t n;

	// ----------------------------------------------------------------
	// Demux, format and path pick
	// ----------------------------------------------------------------
	always_comb
	begin
		n = r;
		n.cfg_s1 = i_cfg;
		n.cfg_s2 = r.cfg_s1;
		n.cfg_s3 = r.cfg_s2;
		// Bits may land on different edges; only a settled word is used
		if (r.cfg_s2 == r.cfg_s3)
			n.cfg_use = r.cfg_s2;
		n.valid = 1'b0;
		if (!r.cfg_use.single_port)
		begin
			// I on port 1, Q on port 2
			n.dac = r.cfg_use.pick_q
				? dprc_pkg::to_twos(i_port2, r.cfg_use.fmt_unsigned)
				: dprc_pkg::to_twos(i_port1, r.cfg_use.fmt_unsigned);
			n.valid = 1'b1;
		end
		else if (i_iq_sel)
		begin
			n.i_hold = dprc_pkg::to_twos(i_port1, r.cfg_use.fmt_unsigned);
		end
		else
		begin
			// Pair completes on the Q word
			n.dac = r.cfg_use.pick_q ? dprc_pkg::to_twos(i_port1, r.cfg_use.fmt_unsigned)
				: r.i_hold;
			n.valid = 1'b1;
		end
	end

	always_ff @(posedge i_lclk or negedge i_nrst)
	begin
		if (!i_nrst)
			r <= '0;
		else
			r <= n;
	end

	assign o_dac_data  = r.dac;
	assign o_dac_valid = r.valid;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_two_port_pick: assert property (@(posedge i_lclk) disable iff (!i_nrst)
		!r.cfg_use.single_port && !r.cfg_use.fmt_unsigned
		|=> o_dac_valid
		&& o_dac_data == ($past(r.cfg_use.pick_q) ? $past(i_port2) : $past(i_port1)))
		else $error("two-port path pick wrong");
	a_format_flip: assert property (@(posedge i_lclk) disable iff (!i_nrst)
		!r.cfg_use.single_port && r.cfg_use.fmt_unsigned && !r.cfg_use.pick_q
		|=> o_dac_data == {~$past(i_port1[dprc_pkg::SAMPLE_W-1]),
			$past(i_port1[dprc_pkg::SAMPLE_W-2:0])})
		else $error("offset binary not converted");
	a_one_port_iq: assert property (@(posedge i_lclk) disable iff (!i_nrst)
		r.cfg_use.single_port && i_iq_sel |=> !o_dac_valid)
		else $error("I word of interleaved pair emitted alone");
	c_one_port: cover property (@(posedge i_lclk) disable iff (!i_nrst)
		r.cfg_use.single_port && i_iq_sel ##1 !i_iq_sel ##1 o_dac_valid);
endmodule
`default_nettype wire

// ---- tb/dprc_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Baseband source on the parallel sample ports
// ----------------------------------------------------------------
module dprc_src_model
(
	input  wire logic                          i_lclk,
	input  wire logic                          i_nrst,
	input  wire logic                          i_single,
	input  wire logic [dprc_pkg::SAMPLE_W-1:0] i_ival,
	input  wire logic [dprc_pkg::SAMPLE_W-1:0] i_qval,
	output logic      [dprc_pkg::SAMPLE_W-1:0] o_port1,
	output logic      [dprc_pkg::SAMPLE_W-1:0] o_port2,
	output logic                               o_iq_sel
);
	always_ff @(posedge i_lclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_port1  <= '0;
			o_port2  <= '0;
			o_iq_sel <= 1'b0;
		end
		else if (i_single)
		begin
			o_iq_sel <= ~o_iq_sel;
			o_port1  <= o_iq_sel ? i_qval : i_ival;
			// Unused in this mode, so it inverts its last value each cycle
			o_port2  <= ~o_port2;
		end
		else
		begin
			o_iq_sel <= ~o_iq_sel;
			o_port1  <= i_ival;
			o_port2  <= i_qval;
		end
	end
endmodule
`default_nettype wire

// ---- tb/tb_data_port_and_route_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, what) begin checked++; if ((got) !== (exp)) begin err_total++; \
	$display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp); end end
module tb_data_port_and_route_control;
	logic        clk, nrst, lclk, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        lock, slip, jit, pll, loop_en, dual, pin_out, pin_oe_n;
	logic        iq_sel, dac_valid, src_single;
	logic [11:0] p1, p2, dac, src_i, src_q;
	int          err_total, checked, seed;

	dprc_top u_dprc_top (.I_CLK(clk), .I_NRST(nrst), .I_LCLK(lclk), .I_AWADDR(awaddr),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.I_LOOP_LOCK(lock), .I_LOOP_SLIP(slip), .I_LOOP_JITTER(jit), .I_PLL_LOCK(pll),
		.O_LOOP_EN(loop_en), .O_DUAL_PATH(dual), .O_RCLK_PIN_OUT(pin_out),
		.O_RCLK_PIN_OE_N(pin_oe_n), .I_PORT1(p1), .I_PORT2(p2), .I_IQ_SEL(iq_sel),
		.O_DAC_DATA(dac), .O_DAC_VALID(dac_valid));
	dprc_src_model u_dprc_src_model (.i_lclk(lclk), .i_nrst(nrst), .i_single(src_single),
		.i_ival(src_i), .i_qval(src_q), .o_port1(p1), .o_port2(p2), .o_iq_sel(iq_sel));

	// ----------------------------------------------------------------
	// Clocks; link clock phase is unrelated to the system clock
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		lclk = 1'b0;
		#7.3;
		forever #24 lclk = ~lclk;
	end

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= {24'h0, d};
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		`CHK(bvalid, 1'b1, "bvalid")
		`CHK(bresp, er, "bresp")
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		`CHK(rdata, {24'h0, ed}, "rdata")
		`CHK(rresp, er, "rresp")
		rready <= 1'b0;
	endtask

	task automatic drv(input logic l, input logic sl, input logic j, input logic pl);
		@(posedge clk);
		lock <= l;
		slip <= sl;
		jit  <= j;
		pll  <= pl;
		repeat (6) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Route check against integer model of the sample path
	// ----------------------------------------------------------------
	task automatic route(input logic f, input logic s, input logic b, input logic p);
		logic [11:0] iv, qv;
		int e, n;
		wr(dprc_pkg::ADDR_DATA_CTRL, {f, s, 6'h00}, 4'hF, dprc_pkg::RESP_OKAY);
		wr(dprc_pkg::ADDR_FILT_MODE2, b ? {~p, p, 6'h00} : {p, ~p, 6'h00}, 4'hF,
			dprc_pkg::RESP_OKAY);
		wr(dprc_pkg::ADDR_ROUTE_AUX, {6'h00, b, 1'b0}, 4'hF, dprc_pkg::RESP_OKAY);
		iv = 12'($random(seed));
		qv = 12'($random(seed));
		@(posedge lclk);
		src_i      <= iv;
		src_q      <= qv;
		src_single <= s;
		repeat (12) @(posedge lclk);
		e = ((p ? int'(qv) : int'(iv)) + (f ? 2048 : 0)) % 4096;
		n = 0;
		do
		begin
			@(negedge lclk);
			n++;
		end while (dac_valid !== 1'b1 && n < 8);
		`CHK(dac, 12'(e), "sample")
		`CHK(dual, b, "dual path")
		@(negedge lclk);
		`CHK(dac_valid, ~s, "valid cadence")
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		err_total++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic pv;
		int flips;
		seed = 32'h02D07FD0;
		err_total = 0;
		checked = 0;
		nrst = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{lock, slip, jit, pll, src_single} = '0;
		src_i = '0;
		src_q = '0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rdc(dprc_pkg::ADDR_DATA_CTRL, dprc_pkg::RST_DATA_CTRL, dprc_pkg::RESP_OKAY);
		rdc(dprc_pkg::ADDR_FILT_MODE2, dprc_pkg::RST_FILT_MODE2, dprc_pkg::RESP_OKAY);
		rdc(dprc_pkg::ADDR_ROUTE_AUX, dprc_pkg::RST_ROUTE_AUX, dprc_pkg::RESP_OKAY);
		`CHK({loop_en, dual, pin_oe_n}, 3'h1, "reset outputs")
		$display("test reset done");
		wr(8'h00, 8'hA5, 4'hF, dprc_pkg::RESP_SLVERR);
		rdc(8'h14, 8'h00, dprc_pkg::RESP_SLVERR);
		wr(dprc_pkg::ADDR_FILT_MODE2, 8'h5A, 4'hE, dprc_pkg::RESP_OKAY);
		rdc(dprc_pkg::ADDR_FILT_MODE2, 8'h00, dprc_pkg::RESP_OKAY);
		$display("test refusals done");
		wr(dprc_pkg::ADDR_DATA_CTRL, 8'hFF, 4'hF, dprc_pkg::RESP_OKAY);
		rdc(dprc_pkg::ADDR_DATA_CTRL, 8'hF8, dprc_pkg::RESP_OKAY);
		`CHK({loop_en, pin_oe_n}, 2'h0, "pin driven")
		pv = pin_out;
		flips = 0;
		repeat (16)
		begin
			@(posedge clk);
			if (pin_out !== pv) flips++;
			pv = pin_out;
		end
		`CHK(flips, 16 / (int'(dprc_pkg::RATE_DIV_HALF) + 1), "pin clock runs")
		$display("test pin direction done");
		wr(dprc_pkg::ADDR_DATA_CTRL, 8'h10, 4'hF, dprc_pkg::RESP_OKAY);
		repeat (2) @(posedge clk);
		`CHK({loop_en, pin_oe_n}, 2'h3, "loop on")
		drv(1'b0, 1'b1, 1'b0, 1'b0);
		rdc(dprc_pkg::ADDR_DATA_CTRL, 8'h10, dprc_pkg::RESP_OKAY);
		drv(1'b1, 1'b0, 1'b0, 1'b0);
		rdc(dprc_pkg::ADDR_DATA_CTRL, 8'h14, dprc_pkg::RESP_OKAY);
		drv(1'b0, 1'b0, 1'b1, 1'b0);
		rdc(dprc_pkg::ADDR_DATA_CTRL, 8'h15, dprc_pkg::RESP_OKAY);
		drv(1'b0, 1'b1, 1'b0, 1'b0);
		drv(1'b0, 1'b0, 1'b0, 1'b0);
		rdc(dprc_pkg::ADDR_DATA_CTRL, 8'h16, dprc_pkg::RESP_OKAY);
		wr(dprc_pkg::ADDR_DATA_CTRL, 8'h11, 4'hF, dprc_pkg::RESP_OKAY);
		rdc(dprc_pkg::ADDR_DATA_CTRL, 8'h16, dprc_pkg::RESP_OKAY);
		$display("test loop status done");
		wr(dprc_pkg::ADDR_ROUTE_AUX, 8'h05, 4'hF, dprc_pkg::RESP_OKAY);
		for (int k = 0; k < 2; k++)
		begin
			drv(1'b0, 1'b0, 1'b0, k[0]);
			`CHK({loop_en, pin_oe_n, pin_out}, {2'h0, k[0]}, "lock on pin")
		end
		wr(dprc_pkg::ADDR_ROUTE_AUX, 8'h01, 4'hF, dprc_pkg::RESP_OKAY);
		repeat (2) @(posedge clk);
		`CHK({loop_en, pin_oe_n}, 2'h3, "option needs pll")
		$display("test lock pin done");
		for (int k = 0; k < 16; k++)
			route(k[3], k[2], k[1], k[0]);
		$display("test routing done");
		print_verdict();
	end
endmodule
`default_nettype wire
